// File: shared/pmt_defines.vh
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH

// register byte addresses
`define PMT_ADDR_CONTROL   8'h00
`define PMT_ADDR_COUNT     8'h04
`define PMT_ADDR_PERIOD    8'h08
`define PMT_ADDR_FLAGS     8'h0C
`define PMT_ADDR_ENABLES   8'h10

// control field positions
`define PMT_CTL_POST_HI    6
`define PMT_CTL_POST_LO    3
`define PMT_CTL_RUN        2
`define PMT_CTL_PRE_HI     1
`define PMT_CTL_PRE_LO     0

// flag and enable bit position
`define PMT_MATCH_BIT      1

// reset values
`define PMT_RST_CONTROL    8'h00
`define PMT_RST_COUNT      8'h00
`define PMT_RST_PERIOD     8'hFF

// instruction clock is the system clock divided by this count plus one
`define PMT_INSTR_DIV      2'h3

// prescale terminal counts (divide minus one)
`define PMT_PRE_DIV1       4'h0
`define PMT_PRE_DIV4       4'h3
`define PMT_PRE_DIV16      4'hF

`endif

// File: logic/pmt_timer.v
// Functional notes
// R1: when running, count advances by one from zero per prescaled instruction tick.
// R2: prescale select 00 divides by 1, 01 by 4, 1x by 16.
// R3: count compared with period each cycle; equality at a prescaled instruction tick gives match pulse.
// R4: on match count loads zero next tick; postscaler advances by one.
// R5: reset clears count and sets period to all ones.
// R6: count write, control write or reset clears prescaler and postscaler.
// R7: control write leaves count value unchanged.
// R8: postscale field plus one matches per flag event.
// R9: postscaler completion latches match flag at bit 1 of flag register.
// R10: flag raises interrupt only while enable bit 1 is set.
// R11: run bit 2 of control starts and stops the timer.
// R12: control: postscale 6..3, run 2, prescale 1..0, bit 7 reads zero.
// R13: count and period readable and writable directly, unbuffered.
// R14: unscaled match pulse offered to capture/compare/pwm logic.
// R15: match pulse offered as serial port shift clock source.
// R16: count and period are both eight bits wide.
// R17: with run clear, counters hold and no match or flag occurs.
// R18: match flag stays set until software clears it.
`include "pmt_defines.vh"

module pmt_timer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq,
	output reg         ccp_time_base,
	output reg         ssp_shift_clock
);

////////////////////////////////////////////////////////////////////////////////
// register bus

	reg  [6:0] timer_control;
	reg  [7:0] count_value;   // [R16]
	reg  [7:0] period_value;  // [R16]
	reg        match_flag;
	reg        match_irq_enable;
	reg  [1:0] instr_div;
	reg  [3:0] prescale_count;
	reg  [3:0] postscale_count;

	reg  [31:0] next_prdata;

	wire       wr_access;
	wire       addr_ok;
	wire       wr_control;
	wire       wr_count;
	wire       wr_period;
	wire       wr_flags;
	wire       wr_enables;

	// zero wait states: every access completes in its first access cycle
	assign pready    = 1'b1;
	assign wr_access = psel & penable & pwrite;
	assign addr_ok   = (paddr == `PMT_ADDR_CONTROL) | (paddr == `PMT_ADDR_COUNT) |
	                   (paddr == `PMT_ADDR_PERIOD)  | (paddr == `PMT_ADDR_FLAGS) |
	                   (paddr == `PMT_ADDR_ENABLES);
	assign pslverr   = psel & penable & ~addr_ok;

	assign wr_control = wr_access & (paddr == `PMT_ADDR_CONTROL);
	assign wr_count   = wr_access & (paddr == `PMT_ADDR_COUNT);
	assign wr_period  = wr_access & (paddr == `PMT_ADDR_PERIOD);
	assign wr_flags   = wr_access & (paddr == `PMT_ADDR_FLAGS);
	assign wr_enables = wr_access & (paddr == `PMT_ADDR_ENABLES);

	always @*
	begin
		case (paddr)
			`PMT_ADDR_CONTROL: next_prdata = {25'h0000000, timer_control}; // [R12]
			`PMT_ADDR_COUNT:   next_prdata = {24'h000000, count_value};    // [R13]
			`PMT_ADDR_PERIOD:  next_prdata = {24'h000000, period_value};   // [R13]
			`PMT_ADDR_FLAGS:   next_prdata = {30'h00000000, match_flag, 1'b0};
			`PMT_ADDR_ENABLES: next_prdata = {30'h00000000, match_irq_enable, 1'b0};
			default:           next_prdata = 32'h00000000;
		endcase
	end

	// captured in the setup cycle: leaves a flip-flop yet needs no wait state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable)
			prdata <= next_prdata;
	end

////////////////////////////////////////////////////////////////////////////////
// timer core

	wire       run;
	wire [1:0] prescale_select;
	wire [3:0] postscale_select;
	wire       instr_tick;
	wire       pre_tick;
	wire       match;
	wire       post_done;
	reg  [3:0] pre_limit;

	assign run              = timer_control[`PMT_CTL_RUN];                     // [R11]
	assign prescale_select  = timer_control[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO];
	assign postscale_select = timer_control[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];

	always @*
	begin
		case (prescale_select)
			2'h0:    pre_limit = `PMT_PRE_DIV1;  // [R2]
			2'h1:    pre_limit = `PMT_PRE_DIV4;  // [R2]
			default: pre_limit = `PMT_PRE_DIV16; // [R2]
		endcase
	end

	assign instr_tick = run & (instr_div == `PMT_INSTR_DIV);  // [R1] [R17]
	assign pre_tick   = instr_tick & (prescale_count == pre_limit);
	// compare runs continuously; the pulse is qualified by the tick so that a
	// stopped timer sitting on its period value does not keep firing
	assign match      = pre_tick & (count_value == period_value); // [R3] [R17]
	assign post_done  = match & (postscale_count == postscale_select); // [R8]

	// instruction clock phase divider; held while stopped
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr_div <= 2'h0;
		else if (run)
			instr_div <= instr_div + 2'h1;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale_count <= 4'h0;                  // [R6]
		else if (wr_count | wr_control)
			prescale_count <= 4'h0;                  // [R6]
		else if (pre_tick)
			prescale_count <= 4'h0;
		else if (instr_tick)
			prescale_count <= prescale_count + 4'h1;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			postscale_count <= 4'h0;                 // [R6]
		else if (wr_count | wr_control)
			postscale_count <= 4'h0;                 // [R6]
		else if (post_done)
			postscale_count <= 4'h0;
		else if (match)
			postscale_count <= postscale_count + 4'h1; // [R4]
	end

	// control writes never touch the count register
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_value <= `PMT_RST_COUNT;           // [R5]
		else if (wr_count)
			count_value <= pwdata[7:0];              // [R13] [R7]
		else if (match)
			count_value <= 8'h00;                    // [R4]
		else if (pre_tick)
			count_value <= count_value + 8'h01;      // [R1]
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_value <= `PMT_RST_PERIOD;         // [R5]
		else if (wr_period)
			period_value <= pwdata[7:0];             // [R13]
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_control <= 7'h00;
		else if (wr_control)
			timer_control <= pwdata[6:0];            // [R12]
	end

////////////////////////////////////////////////////////////////////////////////
// interrupt flag and enable

	// set wins over a simultaneous write-one-to-clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			match_flag <= 1'b0;
		else if (post_done)
			match_flag <= 1'b1;                      // [R9]
		else if (wr_flags & pwdata[`PMT_MATCH_BIT])
			match_flag <= 1'b0;                      // [R18]
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			match_irq_enable <= 1'b0;
		else if (wr_enables)
			match_irq_enable <= pwdata[`PMT_MATCH_BIT];
	end

	assign irq = match_flag & match_irq_enable;      // [R10]

	// registered copies of the unscaled match for neighbouring peripherals
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ccp_time_base   <= 1'b0;
			ssp_shift_clock <= 1'b0;
		end
		else
		begin
			ccp_time_base   <= match;                // [R14]
			ssp_shift_clock <= match;                // [R15]
		end
	end

endmodule

// File: dv/pmt_checker.sv
module pmt_checker (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        irq,
	input logic        ccp_time_base,
	input logic        ssp_shift_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (pready) else $error("ready low");
	a_shift_same: assert property (ssp_shift_clock == ccp_time_base) else $error("ssp");
	// one instruction tick at least between matches
	a_pulse_gap: assert property (ccp_time_base |=> !ccp_time_base [*3]) else $error("gap");
	a_ctl_bit7: assert property (psel && penable && paddr == 8'h00
		|-> prdata[31:7] == 0) else $error("b7");
	a_count_width: assert property (psel && penable && paddr == 8'h04
		|-> prdata[31:8] == 0) else $error("w");
	a_bad_addr: assert property (psel && penable && paddr > 8'h10 |-> pslverr && prdata == 0)
		else $error("err");
	a_irq_mask: assert property (psel && penable && !pwrite && paddr == 8'h10
		&& !prdata[1] |-> !irq) else $error("irq");
	// a match on the write edge may still show its pulse
	a_stop_quiet: assert property (psel && penable && pwrite && paddr == 8'h00 && !pwdata[2]
		|-> ##3 !ccp_time_base [*5]) else $error("stop");
	c_irq: cover property (irq);
	c_pulse: cover property (ccp_time_base);
	c_err: cover property (pslverr);
endmodule

bind pmt_timer pmt_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .ccp_time_base(ccp_time_base),
	.ssp_shift_clock(ssp_shift_clock));

// File: dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, irq, capture_compare_pwm, ssp, se;
	int          n_mismatch, num_checks, seed = 32'hc659, p, d, np, k;
	time         t;
	always #25 pclk = ~pclk;
	pmt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .ccp_time_base(capture_compare_pwm), .ssp_shift_clock(ssp));
	task conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] dt);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		r = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		apb(0, a, 0);
		chk(r, e);
	endtask
	task pulse();
		do @(posedge pclk); while (capture_compare_pwm !== 1);
	endtask
	// longest case is sixteen matches at divide by sixteen
	initial
	begin
		#(40000 * 50);
		n_mismatch++;
		conclude();
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rd(8'h00, 0);
		rd(8'h04, 0);
		rd(8'h08, 8'hFF);
		apb(1, 8'h00, 32'hFB);
		rd(8'h00, 32'h7B);
		d = $random(seed);
		apb(1, 8'h08, d);
		rd(8'h08, d & 255);
		rd(8'h14, 0);
		chk(se, 1);
		apb(1, 8'h10, 2);
		rd(8'h10, 2);
		for (int i = 0; i < 5; i++)
		begin
			p = 1 + ($random(seed) & 3);
			d = i == 0 ? 1 : i == 1 ? 4 : 16;
			apb(1, 8'h08, p);
			apb(1, 8'h04, 0);
			apb(1, 8'h00, (i * 5 % 16) << 3 | 4 | (i == 4 ? 2 : i));
			apb(1, 8'h0C, 2);
			np = 0;
			k = 0;
			while (k < 3)
			begin
				@(posedge pclk);
				np += (capture_compare_pwm === 1);
				k += (irq === 1);
			end
			chk(np, i * 5 % 16 + 1);
			pulse();
			t = $time;
			pulse();
			chk(($time - t) / 50, 4 * d * (p + 1));
			$display("test %0d done", i);
		end
		apb(1, 8'h10, 0);
		chk(irq, 0);
		rd(8'h10, 0);
		apb(1, 8'h00, 0);
		apb(1, 8'h04, 8'h37);
		apb(1, 8'h00, 32'h33);
		repeat (200) @(posedge pclk);
		rd(8'h04, 8'h37);
		rd(8'h0C, 2);
		apb(1, 8'h0C, 2);
		rd(8'h0C, 0);
		apb(1, 8'h08, 8'h5A);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(8'h04, 0);
		rd(8'h08, 8'hFF);
		rd(8'h00, 0);
		$display("test reset done");
		conclude();
	end
endmodule
